// [rtl/bsp_pkg.sv]
// Shared constants for the board status port and the host bus end.
// Assumes one 20 MHz clock, synchronous active-high reset on both ends.
package bsp_pkg;
    // ------------------------------------------------------------
    // Status port local offsets and field positions
    // ------------------------------------------------------------
    localparam int LOCAL_BITS = 3;
    localparam logic [2:0] OFS_SWITCH = 3'h0;
    localparam logic [2:0] OFS_IDENT = 3'h1;
    localparam logic [2:0] OFS_STATUS = 3'h2;
    localparam logic [2:0] OFS_ERR_CLEAR = 3'h3;
    localparam logic [2:0] OFS_EXP_A = 3'h4;
    localparam logic [2:0] OFS_EXP_B = 3'h5;
    localparam logic [2:0] OFS_RSVD_SIX = 3'h6;
    localparam logic [2:0] OFS_RSVD_SEVEN = 3'h7;
    localparam int ERR_WIDTH = 4;
    localparam int ERR_LSB = 0;
    localparam int UART_IRQ_BIT = 4;
    localparam int CLOCK_IRQ_BIT = 5;
    localparam int TEMP_IRQ_BIT = 6;
    localparam int SWITCH_WIDTH = 4;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [7:0] DATA_IDLE = 8'hFF;

    // ------------------------------------------------------------
    // Host bus configuration words and windows
    // ------------------------------------------------------------
    localparam int ADDR_WIDTH = 24;
    localparam int WINDOW_BITS = 12;
    localparam logic [15:0] STATUS_WINDOW_CONFIG = 16'hFFE0;
    localparam logic [15:0] STATUS_BUS_CONFIG = 16'h040D;
    localparam logic [15:0] UART_WINDOW_CONFIG = 16'hFFE0;
    localparam logic [15:0] UART_BUS_CONFIG = 16'h040D;
    localparam logic [23:0] STATUS_WINDOW_START = 24'hFF_F000;
    localparam logic [23:0] STATUS_WINDOW_END = 24'hFF_FFFF;
    localparam logic [23:0] UART_WINDOW_START = 24'hFF_E000;
    localparam logic [23:0] UART_WINDOW_END = 24'hFF_EFFF;
    localparam int WAIT_FIELD_LSB = 0;
    localparam int TRISTATE_FIELD_BIT = 5;
    // Wait states = 15 - wait_state_field, tristates = 1 - tristate_field
    localparam int WAIT_STATES = 15 - int'(STATUS_BUS_CONFIG[3:0]);
    localparam int TRISTATE_CYCLES = 1 - int'(STATUS_BUS_CONFIG[TRISTATE_FIELD_BIT]);
    localparam int BASE_STROBE_CYCLES = 2;
    localparam int STROBE_CYCLES = BASE_STROBE_CYCLES + WAIT_STATES;
    // Idle gap lets the port's two-stage input sync release the data bus
    localparam int GAP_CYCLES = 3;

    // ------------------------------------------------------------
    // Host register map (Wishbone byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] HREG_ADDR = 8'h00;
    localparam logic [7:0] HREG_DATA = 8'h04;
    localparam logic [7:0] HREG_CMD = 8'h08;
    localparam logic [7:0] HREG_STAT = 8'h0C;
    localparam logic [7:0] HREG_MASK = 8'h10;
    localparam logic [7:0] HREG_CFG = 8'h14;
    localparam int CMD_READ_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_BUSY_BIT = 0;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_REFUSED_BIT = 1;
    localparam int EV_WIDTH = 2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    typedef enum {
        BSP_IDLE,
        BSP_SETUP,
        BSP_STROBE,
        BSP_TRISTATE,
        BSP_GAP
    } bsp_state_type;
endpackage

// [rtl/bsp_bus_if.sv]
// External 8-bit demultiplexed bus between host and status port.
// Resolves data to DATA_IDLE, a weak pull-up view, when nobody drives it.
`timescale 1ns/100ps
interface bsp_bus_if;
    logic [23:0] addr;
    logic status_port_select_n;
    logic uart_select_n;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic [7:0] host_data;
    logic host_oe;
    logic [7:0] dev_data;
    logic dev_oe;
    logic [7:0] data;

    // Resolved level of the shared data lines
    assign data = dev_oe ? dev_data : (host_oe ? host_data : bsp_pkg::DATA_IDLE);

    modport host (
        output addr, status_port_select_n, uart_select_n, rd_n, wr_n, ale,
        output host_data, host_oe,
        input data
    );
    modport device (
        input addr, status_port_select_n, rd_n, wr_n, data,
        output dev_data, dev_oe
    );
endinterface

// [rtl/bsp_status_port.sv]
// Board status port: read-only status bytes on the external bus.
// Assumes bus pins are asynchronous to clk_i; select, rd_n and the low three address bits pass two flops.
`timescale 1ns/100ps
module bsp_status_port (
    input wire logic clk_i,
    input wire logic rst_i,
    bsp_bus_if.device bus,
    input wire logic [3:0] switch_setting_i,
    input wire logic [7:0] module_config_ident_i,
    input wire logic [3:0] driver_error_i,
    input wire logic uart_irq_i,
    input wire logic clock_irq_i,
    input wire logic temp_irq_i,
    output logic expansion_select_a_n_o,
    output logic expansion_select_b_n_o,
    output logic error_latched_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 2 + bsp_pkg::LOCAL_BITS + 19;
    logic [SYNC_W-1:0] pin_meta_reg;
    logic [SYNC_W-1:0] pin_sync_reg;
    wire [SYNC_W-1:0] pin_raw = {bus.status_port_select_n, bus.rd_n,
        bus.addr[bsp_pkg::LOCAL_BITS-1:0], switch_setting_i, module_config_ident_i,
        driver_error_i, uart_irq_i, clock_irq_i, temp_irq_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= {2'b11, {(SYNC_W-2){1'b0}}};
            pin_sync_reg <= {2'b11, {(SYNC_W-2){1'b0}}};
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire sel_n = pin_sync_reg[SYNC_W-1];
    wire rd_n = pin_sync_reg[SYNC_W-2];
    wire [2:0] ofs = pin_sync_reg[SYNC_W-3 -: 3];
    wire [3:0] sw = pin_sync_reg[18:15];
    wire [7:0] ident = pin_sync_reg[14:7];
    wire [3:0] err_in = pin_sync_reg[6:3];
    wire uart_irq = pin_sync_reg[2];
    wire clock_irq = pin_sync_reg[1];
    wire temp_irq = pin_sync_reg[0];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Write strobe is deliberately not sampled: writes change nothing but the expansion selects
    wire access = ~sel_n;
    wire rd_active = access & ~rd_n; // [RQ1]
    logic rd_active_d_reg;
    wire rd_start = rd_active & ~rd_active_d_reg;
    wire err_clear = rd_start & (ofs == bsp_pkg::OFS_ERR_CLEAR); // [RQ4]
    // Offsets 4 to 7 leave the bus to the expansion or to nobody
    wire drives = rd_active & ~ofs[2]; // [RQ6]

    logic [3:0] err_reg;
    logic [3:0] err_next;
    // A fault in the clearing cycle survives the clear
    assign err_next = (err_reg & ~{4{err_clear}}) | err_in; // [RQ14]

    logic [7:0] status_byte;
    always_comb begin
        status_byte = 8'h00;
        status_byte[bsp_pkg::ERR_LSB +: bsp_pkg::ERR_WIDTH] = err_reg; // [RQ3]
        status_byte[bsp_pkg::UART_IRQ_BIT] = uart_irq;
        status_byte[bsp_pkg::CLOCK_IRQ_BIT] = clock_irq;
        status_byte[bsp_pkg::TEMP_IRQ_BIT] = temp_irq;
    end

    logic [7:0] read_mux;
    always_comb begin
        unique case (ofs)
            bsp_pkg::OFS_SWITCH: read_mux = {4'h0, sw}; // [RQ2]
            bsp_pkg::OFS_IDENT: read_mux = ident; // [RQ2]
            bsp_pkg::OFS_STATUS: read_mux = status_byte; // [RQ3]
            default: read_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------
    logic [7:0] data_reg;
    logic oe_reg;
    logic exp_a_n_reg;
    logic exp_b_n_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_active_d_reg <= 1'b0;
            err_reg <= bsp_pkg::ERR_RESET[3:0];
            data_reg <= 8'h00;
            oe_reg <= 1'b0;
            exp_a_n_reg <= 1'b1;
            exp_b_n_reg <= 1'b1;
        end else begin
            rd_active_d_reg <= rd_active;
            err_reg <= err_next; // [RQ14]
            data_reg <= read_mux;
            oe_reg <= drives;
            exp_a_n_reg <= ~(access & (ofs == bsp_pkg::OFS_EXP_A)); // [RQ5]
            exp_b_n_reg <= ~(access & (ofs == bsp_pkg::OFS_EXP_B)); // [RQ5]
        end
    end

    assign bus.dev_data = data_reg;
    assign bus.dev_oe = oe_reg;
    assign expansion_select_a_n_o = exp_a_n_reg;
    assign expansion_select_b_n_o = exp_b_n_reg;
    assign error_latched_o = |err_reg;
endmodule

// [rtl/bsp_host_bus.sv]
// Host end: Wishbone-controlled master of the external status/UART bus.
// Assumes a classic Wishbone master on clk_i; no ready line on the bus.
//
// Overview of operation
// RQ1: Status port answers reads only, ignores writes.
// RQ2: Offset 0 switches, offset 1 configuration identifier.
// RQ3: Offset 2 error flags and three interrupts.
// RQ4: Reading offset 3 clears latched errors.
// RQ5: Offsets 4 and 5 drive expansion selects.
// RQ6: Offsets 6 and 7 reserved, undecoded.
// RQ7: Host uses 8-bit demultiplexed bus for port.
// RQ8: Port accesses use two waits, one tristate.
// RQ9: Port window example FFF000h to FFFFFFh.
// RQ10: UART select uses 8-bit demultiplexed bus.
// RQ11: UART accesses use two waits, one tristate.
// RQ12: UART window example FFE000h to FFEFFFh.
// RQ13: Select before strobes, normal latch, no ready.
// RQ14: Error flags stay latched until clearing read.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module bsp_host_bus #(
    parameter logic [23:0] STATUS_START = bsp_pkg::STATUS_WINDOW_START,
    parameter logic [23:0] UART_START = bsp_pkg::UART_WINDOW_START
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    bsp_bus_if.host bus
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic in_window(input logic [23:0] addr,
                                       input logic [23:0] start);
        return addr[23:bsp_pkg::WINDOW_BITS] == start[23:bsp_pkg::WINDOW_BITS];
    endfunction

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [23:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [1:0] stat_reg;
    logic [1:0] mask_reg;
    logic busy;

    wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    // Writes take effect on the edge after ack is raised, where the master samples it
    wire wb_fire = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i;
    wire hit_addr = wb_adr_i == bsp_pkg::HREG_ADDR;
    wire hit_data = wb_adr_i == bsp_pkg::HREG_DATA;
    wire hit_cmd = wb_adr_i == bsp_pkg::HREG_CMD;
    wire hit_stat = wb_adr_i == bsp_pkg::HREG_STAT;
    wire hit_mask = wb_adr_i == bsp_pkg::HREG_MASK;
    wire hit_cfg = wb_adr_i == bsp_pkg::HREG_CFG;

    wire cmd_wr = wb_fire & hit_cmd & wb_sel_i[0];
    wire start_rd = cmd_wr & wb_dat_i[bsp_pkg::CMD_READ_BIT];
    wire start_wr = cmd_wr & wb_dat_i[bsp_pkg::CMD_WRITE_BIT] & ~start_rd;
    wire start_any = start_rd | start_wr;
    wire hit_status_win = in_window(addr_reg, STATUS_START); // [RQ9]
    wire hit_uart_win = in_window(addr_reg, UART_START); // [RQ12]
    wire refuse = start_any & (busy | ~(hit_status_win | hit_uart_win));
    wire launch = start_any & ~refuse;
    wire [31:0] addr_merged = merge_bytes({8'h00, addr_reg}, wb_dat_i, wb_sel_i);

    logic [31:0] read_mux;
    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_addr) begin
            read_mux = {8'h00, addr_reg};
        end else if (hit_data) begin
            read_mux = {24'h00_0000, rdata_reg};
        end else if (hit_cmd) begin
            read_mux[bsp_pkg::CMD_BUSY_BIT] = busy;
        end else if (hit_stat) begin
            read_mux[bsp_pkg::EV_WIDTH-1:0] = stat_reg;
        end else if (hit_mask) begin
            read_mux[bsp_pkg::EV_WIDTH-1:0] = mask_reg;
        end else if (hit_cfg) begin
            read_mux = {bsp_pkg::STATUS_WINDOW_CONFIG, bsp_pkg::STATUS_BUS_CONFIG};
        end
    end

    // ------------------------------------------------------------
    // External bus sequencer
    // ------------------------------------------------------------
    bsp_pkg::bsp_state_type state_reg;
    bsp_pkg::bsp_state_type state_next;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic is_write_reg;
    logic use_uart_reg;
    logic done_ev;
    wire count_end = count_reg == 4'h0;

    assign busy = state_reg != bsp_pkg::BSP_IDLE;

    always_comb begin
        state_next = state_reg;
        count_next = count_end ? 4'h0 : 4'(count_reg - 4'h1);
        done_ev = 1'b0;
        unique case (state_reg)
            bsp_pkg::BSP_IDLE: begin
                if (launch) begin
                    state_next = bsp_pkg::BSP_SETUP; // [RQ13]
                end
            end
            bsp_pkg::BSP_SETUP: begin
                state_next = bsp_pkg::BSP_STROBE;
                count_next = 4'(bsp_pkg::STROBE_CYCLES - 1); // [RQ8] [RQ11]
            end
            bsp_pkg::BSP_STROBE: begin
                if (count_end) begin
                    state_next = bsp_pkg::BSP_TRISTATE;
                    count_next = 4'(bsp_pkg::TRISTATE_CYCLES - 1); // [RQ8] [RQ11]
                end
            end
            bsp_pkg::BSP_TRISTATE: begin
                if (count_end) begin
                    state_next = bsp_pkg::BSP_GAP;
                    count_next = 4'(bsp_pkg::GAP_CYCLES - 1);
                end
            end
            bsp_pkg::BSP_GAP: begin
                if (count_end) begin
                    state_next = bsp_pkg::BSP_IDLE;
                    done_ev = 1'b1;
                end
            end
        endcase
    end

    // Read data is taken on the edge that ends the strobe
    wire sample_rd = (state_reg == bsp_pkg::BSP_STROBE) & count_end & ~is_write_reg;
    wire [1:0] ev_set = {refuse, done_ev};
    // A new event beats a clear written in the same cycle
    wire [1:0] stat_next = (wb_fire & hit_stat & wb_sel_i[0]) ?
        ((stat_reg & ~wb_dat_i[1:0]) | ev_set) : (stat_reg | ev_set);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= bsp_pkg::REG_RESET;
            addr_reg <= bsp_pkg::REG_RESET[23:0];
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            stat_reg <= 2'b00;
            mask_reg <= 2'b00;
        end else begin
            ack_reg <= wb_req;
            if (wb_req) begin
                dat_reg <= read_mux;
            end
            if (wb_fire & hit_addr) begin
                addr_reg <= addr_merged[23:0];
            end
            if (wb_fire & hit_data & wb_sel_i[0]) begin
                wdata_reg <= wb_dat_i[7:0];
            end
            if (sample_rd) begin
                rdata_reg <= bus.data;
            end
            stat_reg <= stat_next;
            if (wb_fire & hit_mask & wb_sel_i[0]) begin
                mask_reg <= wb_dat_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= bsp_pkg::BSP_IDLE;
            count_reg <= 4'h0;
            is_write_reg <= 1'b0;
            use_uart_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            if (launch) begin
                is_write_reg <= start_wr;
                use_uart_reg <= hit_uart_win;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive: 8-bit demultiplexed, select leads strobes
    // ------------------------------------------------------------
    // Pins are registered from the next state so they line up with it
    wire state_next_sel = (state_next == bsp_pkg::BSP_SETUP) |
        (state_next == bsp_pkg::BSP_STROBE) | (state_next == bsp_pkg::BSP_TRISTATE);
    wire next_write = launch ? start_wr : is_write_reg;
    wire next_uart = launch ? hit_uart_win : use_uart_reg;
    logic status_sel_n_reg;
    logic uart_sel_n_reg;
    logic rd_n_reg;
    logic wr_n_reg;
    logic ale_reg;
    logic host_oe_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_sel_n_reg <= 1'b1;
            uart_sel_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            ale_reg <= 1'b0;
            host_oe_reg <= 1'b0;
        end else begin
            status_sel_n_reg <= ~(state_next_sel & ~next_uart); // [RQ7] [RQ13]
            uart_sel_n_reg <= ~(state_next_sel & next_uart); // [RQ10] [RQ13]
            rd_n_reg <= ~(state_next == bsp_pkg::BSP_STROBE & ~next_write); // [RQ13]
            wr_n_reg <= ~(state_next == bsp_pkg::BSP_STROBE & next_write); // [RQ13]
            ale_reg <= state_next == bsp_pkg::BSP_SETUP; // [RQ13]
            host_oe_reg <= next_write & (state_next == bsp_pkg::BSP_SETUP |
                state_next == bsp_pkg::BSP_STROBE);
        end
    end

    assign bus.addr = addr_reg;
    assign bus.host_data = wdata_reg;
    assign bus.host_oe = host_oe_reg;
    assign bus.status_port_select_n = status_sel_n_reg;
    assign bus.uart_select_n = uart_sel_n_reg;
    assign bus.rd_n = rd_n_reg;
    assign bus.wr_n = wr_n_reg;
    assign bus.ale = ale_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = |(stat_reg & mask_reg);
endmodule

// [verification/bsp_chk.sv]
// Checker for the external status bus joining the host end and the status port.
// Assumes it sits beside the bus interface, on the single clock domain.
`timescale 1ns/100ps
module bsp_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [23:0] addr,
    input wire logic status_port_select_n,
    input wire logic uart_select_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale,
    input wire logic [7:0] host_data,
    input wire logic host_oe,
    input wire logic [7:0] dev_data,
    input wire logic dev_oe,
    input wire logic [7:0] data
);
    wire logic sel_any;
    assign sel_any = !(status_port_select_n && uart_select_n);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Bus protocol
    // ------------------------------------------------------------
    a_read_only_drive: assert property ($rose(dev_oe) |->
        !rd_n && wr_n && !status_port_select_n)
        else $error("device drove data outside a status read");
    a_release_data: assert property ($rose(status_port_select_n) |-> ##[0:3] !dev_oe)
        else $error("device held data after deselect");
    a_one_owner: assert property (!(dev_oe && host_oe))
        else $error("host and device drive data together");
    a_undecoded_quiet: assert property ($rose(dev_oe) |-> addr[2] == 1'b0)
        else $error("device drove data at offsets four to seven");
    a_read_strobe: assert property ($fell(rd_n) |-> (!rd_n)[*4] ##1 rd_n)
        else $error("read strobe not four cycles");
    a_write_strobe: assert property ($fell(wr_n) |-> (!wr_n)[*4] ##1 wr_n)
        else $error("write strobe not four cycles");
    a_select_first: assert property ($fell(rd_n) || $fell(wr_n) |-> $past(sel_any))
        else $error("strobe fell without select already low");
    a_select_tristate: assert property ($rose(rd_n) || $rose(wr_n) |->
        sel_any ##1 !sel_any)
        else $error("select not held one tristate cycle");
    a_ale_setup: assert property ($rose(sel_any) |-> ale ##1 !ale)
        else $error("address latch pulse wrong in setup");
    a_status_window: assert property (!status_port_select_n |-> addr[23:12] == 12'hFFF)
        else $error("status select outside its window");
    a_uart_window: assert property (!uart_select_n |-> addr[23:12] == 12'hFFE)
        else $error("uart select outside its window");
    a_one_select: assert property (!(!status_port_select_n && !uart_select_n))
        else $error("both selects low");

    c_read: cover property ($rose(dev_oe));
    c_write: cover property ($fell(wr_n));
    c_uart: cover property ($fell(uart_select_n));
endmodule

// [verification/board_status_port_decoder_bench.sv]
// Self-checking bench: host end and status port joined over the bus interface.
// Assumes a Wishbone master in the bench and the designer's host register map.
`timescale 1ns/100ps
module board_status_port_decoder_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, sw = 4'h0, derr = 4'h0, err_model = 4'h0;
    logic [31:0] wdat = 32'h0, q = 32'h0;
    logic [7:0] ident = 8'h00;
    logic [2:0] ints = 3'h0;
    wire logic [31:0] rdat;
    wire logic ack, irq, exp_a_n, exp_b_n, err_lat;
    int bad_count = 0, cmp_count = 0, cycles = 0, cnt_a = 0, cnt_b = 0, seed = 48;

    bsp_bus_if u_bsp_bus_if ();
    bsp_host_bus u_bsp_host_bus (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .bus(u_bsp_bus_if));
    bsp_status_port u_bsp_status_port (.clk_i(clk_i), .rst_i(rst_i), .bus(u_bsp_bus_if),
        .switch_setting_i(sw), .module_config_ident_i(ident), .driver_error_i(derr),
        .uart_irq_i(ints[0]), .clock_irq_i(ints[1]), .temp_irq_i(ints[2]),
        .expansion_select_a_n_o(exp_a_n), .expansion_select_b_n_o(exp_b_n),
        .error_latched_o(err_lat));
    bsp_chk u_bsp_chk (.clk_i(clk_i), .rst_i(rst_i), .addr(u_bsp_bus_if.addr),
        .status_port_select_n(u_bsp_bus_if.status_port_select_n),
        .uart_select_n(u_bsp_bus_if.uart_select_n), .rd_n(u_bsp_bus_if.rd_n),
        .wr_n(u_bsp_bus_if.wr_n), .ale(u_bsp_bus_if.ale), .host_data(u_bsp_bus_if.host_data),
        .host_oe(u_bsp_bus_if.host_oe), .dev_data(u_bsp_bus_if.dev_data),
        .dev_oe(u_bsp_bus_if.dev_oe), .data(u_bsp_bus_if.data));

    // ------------------------------------------------------------
    // Clock, expansion select counters and hang guard
    // ------------------------------------------------------------
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (!exp_a_n) cnt_a <= cnt_a + 1;
        if (!exp_b_n) cnt_b <= cnt_b + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; no cycle count assumed, only the hang guard ends a wait
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Launch one external access, wait for busy to drop, then fetch the data byte
    task access(input logic [23:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        wb(1'b1, bsp_pkg::HREG_ADDR, {8'h00, a});
        if (w) wb(1'b1, bsp_pkg::HREG_DATA, {24'h00_0000, d});
        wb(1'b1, bsp_pkg::HREG_CMD, w ? 32'h0000_0002 : 32'h0000_0001);
        q = 32'h0000_0001;
        while (q[0] === 1'b1 && n < 40) begin
            wb(1'b0, bsp_pkg::HREG_CMD, 32'h0);
            n = n + 1;
        end
        check(q[0], 1'b0);
        wb(1'b0, bsp_pkg::HREG_DATA, 32'h0);
    endtask

    function automatic logic [7:0] exp_byte(input logic [2:0] o);
        case (o)
            3'h0: return {4'h0, sw};
            3'h1: return ident;
            3'h2: return {1'b0, ints[2], ints[1], ints[0], err_model};
            3'h3: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int ca, cb;
        logic [2:0] o;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, bsp_pkg::HREG_CFG, 32'h0);
        check(q, 32'hFFE0_040D);
        wb(1'b0, bsp_pkg::HREG_STAT, 32'h0);
        check(q, 32'h0);
        check(irq, 1'b0);
        wb(1'b0, 8'h18, 32'h0);
        check(q, 32'h0);
        for (int i = 0; i < 24; i++) begin
            o = 3'(i);
            @(posedge clk_i);
            sw <= 4'($random(seed));
            ident <= 8'($random(seed));
            ints <= 3'($random(seed));
            repeat (4) @(posedge clk_i);
            ca = cnt_a;
            cb = cnt_b;
            access({12'hFFF, 9'($random(seed)), o}, 1'b0, 8'h00);
            check(q[7:0], exp_byte(o));
            check(cnt_a != ca, o == 3'h4);
            check(cnt_b != cb, o == 3'h5);
        end
        @(posedge clk_i);
        derr <= 4'($random(seed)) | 4'h1;
        repeat (4) @(posedge clk_i);
        err_model = derr;
        derr <= 4'h0;
        repeat (4) @(posedge clk_i);
        check(err_lat, 1'b1);
        access(24'hFF_F003, 1'b1, 8'hFF);
        access(24'hFF_F002, 1'b1, 8'h00);
        access(24'hFF_F002, 1'b0, 8'h00);
        check(q[7:0], exp_byte(3'h2));
        access(24'hFF_F00B, 1'b0, 8'h00);
        check(q[7:0], 8'h00);
        err_model = 4'h0;
        access(24'hFF_F002, 1'b0, 8'h00);
        check(q[7:0], exp_byte(3'h2));
        check(err_lat, 1'b0);
        ca = cnt_a;
        access(24'hFF_F7F4, 1'b1, 8'h5A);
        check(cnt_a != ca, 1'b1);
        wb(1'b1, bsp_pkg::HREG_STAT, 32'h0000_0003);
        wb(1'b1, bsp_pkg::HREG_MASK, 32'h0000_0001);
        access(24'hFF_E123, 1'b0, 8'h00);
        check(q[7:0], 8'hFF);
        wb(1'b0, bsp_pkg::HREG_STAT, 32'h0);
        check(q[1:0], 2'b01);
        check(irq, 1'b1);
        wb(1'b1, bsp_pkg::HREG_STAT, 32'h0000_0001);
        access(24'h00_1000, 1'b0, 8'h00);
        wb(1'b0, bsp_pkg::HREG_STAT, 32'h0);
        check(q[1:0], 2'b10);
        check(irq, 1'b0);
        wb(1'b1, bsp_pkg::HREG_MASK, 32'h0000_0003);
        @(posedge clk_i);
        check(irq, 1'b1);
        wb(1'b1, bsp_pkg::HREG_STAT, 32'h0000_0002);
        @(posedge clk_i);
        check(irq, 1'b0);
        // Read wins over write; a start while busy is refused
        wb(1'b1, bsp_pkg::HREG_ADDR, 32'h00FF_F001);
        wb(1'b1, bsp_pkg::HREG_CMD, 32'h0000_0003);
        wb(1'b1, bsp_pkg::HREG_CMD, 32'h0000_0002);
        repeat (12) @(posedge clk_i);
        wb(1'b0, bsp_pkg::HREG_DATA, 32'h0);
        check(q[7:0], exp_byte(3'h1));
        wb(1'b0, bsp_pkg::HREG_STAT, 32'h0);
        check(q[1:0], 2'b11);
        check(irq, 1'b1);
        wrap_up();
    end
endmodule
